// [ham_hdlc_port.sv]
// register port, address filter and fifos for two hdlc controllers
`timescale 1ns/1ns
module ham_hdlc_port
  import ham_pkg::*;
#(
  parameter int DEPTH = FIFO_D
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // parallel register port pins
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_din,
  output logic [7:0] host_dout,
  output logic host_doe,
  // page select from the chip page register
  input wire logic [7:0] page_sel,
  // transmit words toward the bit engines
  output logic [1:0] tx_valid,
  input wire logic [1:0] tx_ready,
  output logic [1:0][7:0] tx_data,
  output logic [1:0] last_byte_tag,
  output logic [1:0] abort_tag,
  // received bytes from the bit engines
  input wire logic [1:0] rx_valid,
  output logic [1:0] rx_ready,
  input wire logic [1:0][7:0] rx_data,
  input wire logic [1:0] rx_last,
  input wire logic [1:0] rx_byte_tag_hi,
  input wire logic [1:0] rx_byte_tag_lo,
  input wire logic [1:0][15:0] rx_check_in,
  // control levels toward the bit engines
  output logic [1:0] rx_enable,
  output logic [1:0] tx_enable,
  output logic [1:0] mark_idle
);
  // whole state of the block
  typedef struct packed {
    ham_ch_t [1:0] ch;
    logic rd_prev;
    logic wr_prev;
    logic oe;
    logic [7:0] rdata;
    logic [3:0] widx;
    logic [7:0] wdata;
    logic wch;
  } ham_top_st_t;
  ham_top_st_t st_reg;
  ham_top_st_t st_next;

  // synchronised pins
  logic [15:0] pin_sync;
  logic s_cs_n;
  logic s_rd_n;
  logic s_wr_n;
  logic [4:0] s_addr;
  logic [7:0] s_din;
  // fifo handshakes, one per controller
  logic [1:0] txf_iv;
  logic [1:0] txf_ir;
  logic [1:0][9:0] txf_id;
  logic [1:0] txf_ov;
  logic [1:0][9:0] txf_od;
  logic [1:0] rxf_iv;
  logic [1:0] rxf_ir;
  logic [1:0][9:0] rxf_id;
  logic [1:0] rxf_ov;
  logic [1:0] rxf_or;
  logic [1:0][9:0] rxf_od;
  // decode helpers
  logic ch;
  logic hit;
  logic rd_act;
  logic wr_act;
  logic quiet;

  // host pins are asynchronous to ref_clk
  ham_sync #(
    .W(16),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in({host_cs_n, host_rd_n, host_wr_n, host_addr, host_din}),
    .sync_out(pin_sync)
  );
  assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_din} = pin_sync;

  // one transmit and one receive fifo per controller
  for (genvar g = 0; g < 2; g++) begin : g_fifo
    ham_fifo #(
      .W(FIFO_W),
      .D(DEPTH)
    ) u_txf (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .flush(st_reg.ch[g].regs[OFS_CTL2[3:0]][C2_TXFRST]),
      .in_valid(txf_iv[g]),
      .in_ready(txf_ir[g]),
      .in_data(txf_id[g]),
      .out_valid(txf_ov[g]),
      .out_ready(tx_ready[g]),
      .out_data(txf_od[g])
    );
    ham_fifo #(
      .W(FIFO_W),
      .D(DEPTH)
    ) u_rxf (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .flush(st_reg.ch[g].regs[OFS_CTL2[3:0]][C2_RXFRST]),
      .in_valid(rxf_iv[g]),
      .in_ready(rxf_ir[g]),
      .in_data(rxf_id[g]),
      .out_valid(rxf_ov[g]),
      .out_ready(rxf_or[g]),
      .out_data(rxf_od[g])
    );
    // transmit word: end tag, abort tag, byte
    assign tx_valid[g] = txf_ov[g];
    assign tx_data[g] = txf_od[g][7:0];
    assign last_byte_tag[g] = txf_od[g][9];
    assign abort_tag[g] = txf_od[g][8];
    // control levels straight from the stored control byte
    assign rx_enable[g] = st_reg.ch[g].regs[OFS_CTL1[3:0]][C1_RXEN];
    assign tx_enable[g] = st_reg.ch[g].regs[OFS_CTL1[3:0]][C1_TXEN];
    assign mark_idle[g] = st_reg.ch[g].regs[OFS_CTL1[3:0]][C1_MIDLE];
  end

  // read-only and fifo offsets are not stored by a write
  function automatic logic is_rw(input logic [3:0] idx);
    logic [4:0] o;
    o = {1'b1, idx};
    is_rw = !(o == OFS_FIFO || o == OFS_STAT || o == OFS_EVFLAGS ||
              o == OFS_CHKH || o == OFS_CHKL || o == OFS_TSTAT);
  endfunction : is_rw

  // address decision; two selects whether a second byte is compared
  function automatic logic addr_pass(input logic [7:0] r1, input logic [7:0] r2,
                                     input logic seven, input logic adrec,
                                     input logic [7:0] b1, input logic [7:0] b2,
                                     input logic two);
    logic m1;
    logic m2;
    logic ac;
    m1 = !r1[AM_EN] || ((b1[7:2] == r1[7:2]) && (!seven || b1[1] == r1[1]));
    m2 = !two || !r2[AM_EN] || (b2[7:1] == r2[7:1]);
    // all-call overrides both masks but needs the enables
    ac = r1[AM_EN] && (b1[7:1] == ALL_CALL) &&
         (!two || (r2[AM_EN] && b2[7:1] == ALL_CALL));
    addr_pass = !adrec || ac || (m1 && m2);
  endfunction : addr_pass

  // page and offset decode
  always_comb begin
    ch = (page_sel == PAGE_CH1);
    hit = ((page_sel == PAGE_CH0) || (page_sel == PAGE_CH1)) &&
          s_addr[4] && (s_addr != OFS_NONE);
    rd_act = !s_cs_n && !s_rd_n && hit;
    wr_act = !s_cs_n && !s_wr_n && hit;
    // no strobe now nor last cycle: pointers have settled
    quiet = !(rd_act || wr_act || st_reg.rd_prev || st_reg.wr_prev);
  end

  // next-state logic: bus port, tag handling, address filter
  always_comb begin
    logic [7:0] r1;
    logic [7:0] r2;
    logic seven;
    logic adrec;
    logic [9:0] inw;
    logic dec;
    r1 = '0;
    r2 = '0;
    seven = 1'b0;
    adrec = 1'b0;
    inw = '0;
    dec = 1'b0;
    st_next = st_reg;
    txf_iv = '0;
    txf_id = '0;
    rxf_iv = '0;
    rxf_id = '0;
    rxf_or = '0;
    rx_ready = '0;
    st_next.rd_prev = rd_act;
    st_next.wr_prev = wr_act;
    st_next.oe = rd_act;
    // read: value caught once at the start of the strobe
    if (rd_act && !st_reg.rd_prev) begin
      unique case (s_addr)
        OFS_FIFO: begin
          // empty fifo reads as zero and pops nothing
          st_next.rdata = rxf_ov[ch] ? rxf_od[ch][7:0] : REG_RST;
          if (rxf_ov[ch]) begin
            rxf_or[ch] = 1'b1;
            st_next.ch[ch].tag = rxf_od[ch][9:8];
          end
        end
        OFS_STAT: st_next.rdata = {2'b00, st_reg.ch[ch].tag, st_reg.ch[ch].snap};
        OFS_EVFLAGS: st_next.rdata = REG_RST;
        OFS_TSTAT: st_next.rdata = REG_RST;
        OFS_CHKH: st_next.rdata = rx_check_in[ch][15:8];
        OFS_CHKL: st_next.rdata = rx_check_in[ch][7:0];
        default: st_next.rdata = st_reg.ch[ch].regs[s_addr[3:0]];
      endcase
    end
    // write: track address and data while the strobe is low
    if (wr_act) begin
      st_next.widx = s_addr[3:0];
      st_next.wdata = s_din;
      st_next.wch = ch;
    end
    // commit on the strobe's release, data has been stable
    if (st_reg.wr_prev && !wr_act) begin
      if ({1'b1, st_reg.widx} == OFS_FIFO) begin
        txf_iv[st_reg.wch] = 1'b1;
        txf_id[st_reg.wch] = {
          st_reg.ch[st_reg.wch].regs[OFS_CTL1[3:0]][C1_EOP],
          st_reg.ch[st_reg.wch].regs[OFS_CTL1[3:0]][C1_FA],
          st_reg.wdata};
        // tags are one-shot; a refused write leaves them armed
        if (txf_ir[st_reg.wch]) begin
          st_next.ch[st_reg.wch].regs[OFS_CTL1[3:0]][C1_EOP] = 1'b0;
          st_next.ch[st_reg.wch].regs[OFS_CTL1[3:0]][C1_FA] = 1'b0;
        end
      end else if (is_rw(st_reg.widx)) begin
        st_next.ch[st_reg.wch].regs[st_reg.widx] = st_reg.wdata;
      end
    end
    // per controller receive filter and status snapshot
    for (int c = 0; c < 2; c++) begin
      r1 = st_reg.ch[c].regs[OFS_ADDR1[3:0]];
      r2 = st_reg.ch[c].regs[OFS_ADDR2[3:0]];
      seven = st_reg.ch[c].regs[OFS_CTL2[3:0]][C2_SEVEN];
      adrec = st_reg.ch[c].regs[OFS_CTL1[3:0]][C1_ADREC];
      inw = {rx_byte_tag_hi[c], rx_byte_tag_lo[c], rx_data[c]};
      dec = 1'b0;
      unique case (st_reg.ch[c].rxs)
        RX_ADDR1: begin
          if (rx_valid[c]) begin
            if (adrec && r2[AM_EN] && !rx_last[c]) begin
              // hold first byte until the second decides
              rx_ready[c] = 1'b1;
              st_next.ch[c].hold = inw;
              st_next.ch[c].rxs = RX_ADDR2;
            end else begin
              dec = addr_pass(r1, r2, seven, adrec, rx_data[c], rx_data[c], 1'b0);
              if (dec) begin
                rxf_iv[c] = 1'b1;
                rxf_id[c] = inw;
                rx_ready[c] = rxf_ir[c];
                if (rxf_ir[c] && !rx_last[c]) begin
                  st_next.ch[c].rxs = RX_PASS;
                end
              end else begin
                rx_ready[c] = 1'b1;
                if (!rx_last[c]) begin
                  st_next.ch[c].rxs = RX_DROP;
                end
              end
            end
          end
        end
        RX_ADDR2: begin
          // second byte is looked at, not taken, in this state
          if (rx_valid[c]) begin
            dec = addr_pass(r1, r2, seven, adrec, st_reg.ch[c].hold[7:0],
                            rx_data[c], 1'b1);
            st_next.ch[c].rxs = dec ? RX_FLUSH : RX_DROP;
          end
        end
        RX_FLUSH: begin
          // held first byte goes in ahead of the second
          rxf_iv[c] = 1'b1;
          rxf_id[c] = st_reg.ch[c].hold;
          if (rxf_ir[c]) begin
            st_next.ch[c].rxs = RX_PASS;
          end
        end
        RX_PASS: begin
          // full receive fifo stalls the engine
          if (rx_valid[c]) begin
            rxf_iv[c] = 1'b1;
            rxf_id[c] = inw;
            rx_ready[c] = rxf_ir[c];
            if (rxf_ir[c] && rx_last[c]) begin
              st_next.ch[c].rxs = RX_ADDR1;
            end
          end
        end
        RX_DROP: begin
          rx_ready[c] = 1'b1;
          if (rx_valid[c] && rx_last[c]) begin
            st_next.ch[c].rxs = RX_ADDR1;
          end
        end
        default: st_next.ch[c].rxs = RX_ADDR1;
      endcase
      // flags frozen while the host port is busy
      if (quiet) begin
        st_next.ch[c].snap = {!txf_ir[c], !txf_ov[c], !rxf_ir[c], !rxf_ov[c]};
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // read data bus
  assign host_dout = st_reg.rdata;
  assign host_doe = st_reg.oe;
endmodule : ham_hdlc_port

// [ham_pkg.sv]
// shared constants and types for the hdlc address match and fifo register front end
package ham_pkg;
  // register page codes that select the two controller instances
  localparam logic [7:0] PAGE_CH0 = 8'h0B;
  localparam logic [7:0] PAGE_CH1 = 8'h0C;
  // register offsets inside a controller page
  localparam logic [4:0] OFS_ADDR1 = 5'h10;
  localparam logic [4:0] OFS_ADDR2 = 5'h11;
  localparam logic [4:0] OFS_FIFO = 5'h12;
  localparam logic [4:0] OFS_CTL1 = 5'h13;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_CTL2 = 5'h15;
  localparam logic [4:0] OFS_EVMASK = 5'h16;
  localparam logic [4:0] OFS_EVFLAGS = 5'h17;
  localparam logic [4:0] OFS_CHKH = 5'h18;
  localparam logic [4:0] OFS_CHKL = 5'h19;
  localparam logic [4:0] OFS_TXLEN = 5'h1A;
  localparam logic [4:0] OFS_TCTL = 5'h1B;
  localparam logic [4:0] OFS_TSTAT = 5'h1C;
  localparam logic [4:0] OFS_CTL3 = 5'h1D;
  localparam logic [4:0] OFS_CTL4 = 5'h1E;
  localparam logic [4:0] OFS_NONE = 5'h1F;
  // field positions
  localparam int C1_ADREC = 7;
  localparam int C1_RXEN = 6;
  localparam int C1_TXEN = 5;
  localparam int C1_EOP = 4;
  localparam int C1_FA = 3;
  localparam int C1_MIDLE = 2;
  localparam int C2_SEVEN = 4;
  localparam int C2_RXFRST = 1;
  localparam int C2_TXFRST = 0;
  localparam int AM_EN = 0;
  // all-call address, seven ones above the extension bit
  localparam logic [6:0] ALL_CALL = 7'h7F;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] SYNC_RST = 16'hE000;
  // fifo shape: 8 data bits plus two tag bits
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 8;
  // receive address filter states, gray along the usual path
  typedef enum logic [2:0] {
    RX_ADDR1 = 3'h0,
    RX_ADDR2 = 3'h1,
    RX_FLUSH = 3'h3,
    RX_PASS = 3'h2,
    RX_DROP = 3'h6
  } ham_rx_state_t;
  // per-controller state
  typedef struct packed {
    logic [15:0][7:0] regs;
    ham_rx_state_t rxs;
    logic [9:0] hold;
    logic [1:0] tag;
    logic [3:0] snap;
  } ham_ch_t;
endpackage : ham_pkg

// [ham_sync.sv]
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module ham_sync #(
  parameter int W = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // pins in, synchronised copy out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ham_sync_st_t;
  ham_sync_st_t st_reg;
  ham_sync_st_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;
endmodule : ham_sync

// [ham_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module ham_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ham_fifo_st_t;
  ham_fifo_st_t st_reg;
  ham_fifo_st_t st_next;
  logic wr;
  logic rd;

  // pointers wrap at the depth, so any depth works
  always_comb begin
    st_next = st_reg;
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    if (wr) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == LAST) ? '0 : st_reg.wp + 1'b1;
    end
    if (rd) begin
      st_next.rp = (st_reg.rp == LAST) ? '0 : st_reg.rp + 1'b1;
    end
    if (wr && !rd) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (rd && !wr) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    // flush drops contents but keeps stale words
    if (flush) begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = (st_reg.cnt != FULL) && !flush;
  assign out_valid = (st_reg.cnt != '0) && !flush;
  assign out_data = st_reg.mem[st_reg.rp];
endmodule : ham_fifo

// [ham_port_chk_assertions.sv]
// concurrent checks on the host port pins and the transmit stream
`timescale 1ns/1ns
module ham_port_chk
  import ham_pkg::*;
#(
  parameter int DEPTH = FIFO_D
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // host pins
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_dout,
  input wire logic host_doe,
  input wire logic [7:0] page_sel,
  // transmit stream and control levels
  input wire logic [1:0] tx_valid,
  input wire logic [1:0] tx_ready,
  input wire logic [1:0][7:0] tx_data,
  input wire logic [1:0] last_byte_tag,
  input wire logic [1:0] rx_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // mapped place on a controller page
  logic hit;
  assign hit = (page_sel == PAGE_CH0 || page_sel == PAGE_CH1) &&
    host_addr >= OFS_ADDR1 && host_addr <= OFS_CTL4;
  // cycles since the write strobe was low, saturating
  logic [3:0] since_wr_reg;
  logic [3:0] since_wr_next;
  always_comb begin
    since_wr_next = since_wr_reg;
    if (!host_wr_n) since_wr_next = 4'h0;
    else if (since_wr_reg != 4'hf) since_wr_next = since_wr_reg + 4'h1;
  end
  // saturate high after reset so nothing counts as a recent write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) since_wr_reg <= 4'hf;
    else since_wr_reg <= since_wr_next;
  end
  // read strobe on a mapped place, then held through the sync delay
  sequence s_rd_start;
    $fell(host_rd_n) && !host_cs_n && hit;
  endsequence
  sequence s_rd_held;
    (!host_rd_n && !host_cs_n) [*3];
  endsequence
  chk_read_answer: assert property (s_rd_start ##1 s_rd_held |-> host_doe)
    else $error("mapped read was not answered");
  chk_doe_decode: assert property (host_doe |-> hit)
    else $error("data bus driven for unmapped place");
  chk_doe_idle: assert property (host_rd_n [*5] |-> !host_doe)
    else $error("data bus driven without read");
  chk_doe_release: assert property ($rose(host_rd_n) |-> ##[0:4] !host_doe)
    else $error("data bus held after read");
  chk_dout_steady: assert property (host_doe && $past(host_doe) |-> $stable(host_dout))
    else $error("read data changed during access");
  chk_tx_hold: assert property (tx_valid[0] && !tx_ready[0] |=>
    tx_valid[0] && $stable({tx_data[0], last_byte_tag[0]}))
    else $error("stalled transmit word changed");
  chk_tx_cause: assert property ($rose(tx_valid[0]) |-> since_wr_reg < 4'h8)
    else $error("transmit word without host write");
  chk_page_split: assert property ((page_sel == PAGE_CH0) [*8] |-> $stable(rx_enable[1]))
    else $error("page zero access changed controller one");
endmodule : ham_port_chk

bind ham_hdlc_port ham_port_chk #(.DEPTH(DEPTH)) u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
  .host_addr(host_addr), .host_dout(host_dout), .host_doe(host_doe), .page_sel(page_sel),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .last_byte_tag(last_byte_tag), .rx_enable(rx_enable));

// [ham_host_model.sv]
// host processor model driving the parallel register pins
`timescale 1ns/1ns
module ham_host_model (
  // clock
  input wire logic ref_clk,
  // pins toward the device
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [4:0] host_addr,
  output logic [7:0] host_din,
  // data bus from the device
  input wire logic [7:0] host_dout,
  input wire logic host_doe
);
  // parked offset, outside every controller page
  localparam logic [4:0] OFS_NONE_Q = 5'h1f;
  // idle pins from time zero
  initial begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = OFS_NONE_Q;
    host_din = 8'h00;
  end
  // write: strobe low three clocks, data held past the commit
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_cs_n <= 1'b0;
    host_wr_n <= 1'b0;
    host_addr <= a;
    host_din <= d;
    repeat (3) @(posedge ref_clk);
    host_cs_n <= 1'b1;
    host_wr_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // released bus: show the inverse so stale data never looks valid
    host_din <= ~d;
  endtask : wr
  // read: hold strobe until the device drives, bounded for refused places
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic hit);
    int n;
    @(posedge ref_clk);
    host_cs_n <= 1'b0;
    host_rd_n <= 1'b0;
    host_addr <= a;
    hit = 1'b0;
    d = 8'h00;
    for (n = 0; n < 8 && !hit; n++) begin
      @(posedge ref_clk);
      hit = host_doe;
      d = host_dout;
    end
    host_cs_n <= 1'b1;
    host_rd_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : rd
endmodule : ham_host_model

// [testbench.sv]
// self-checking bench for the hdlc host port, address filter and fifos
`timescale 1ns/1ns
module testbench;
  import ham_pkg::*;
  // design pins
  logic ref_clk, arst_n, host_cs_n, host_rd_n, host_wr_n, host_doe;
  logic [4:0] host_addr;
  logic [7:0] host_din, host_dout, page_sel;
  logic [1:0] tx_valid, tx_ready, last_byte_tag, abort_tag, rx_valid, rx_ready, rx_last;
  logic [1:0] rx_byte_tag_hi, rx_byte_tag_lo, rx_enable, tx_enable, mark_idle;
  logic [1:0][7:0] tx_data, rx_data;
  logic [1:0][15:0] rx_check_in;
  // bench state
  int seed, fails, n_checks, cyc, k, j;
  logic [15:0] v;
  logic [7:0] d, r1, r2, c1, c2;
  logic h;
  logic [7:0] p [3];
  logic [1:0] tg [3];
  logic [9:0] txq [$];
  logic [9:0] exq [$];
  logic [4:0] rw_ofs [7] = '{OFS_ADDR1, OFS_ADDR2, OFS_EVMASK, OFS_TXLEN, OFS_TCTL,
    OFS_CTL3, OFS_CTL4};
  ham_hdlc_port #(.DEPTH(FIFO_D)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_addr(host_addr), .host_din(host_din), .host_dout(host_dout),
    .host_doe(host_doe), .page_sel(page_sel), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .last_byte_tag(last_byte_tag), .abort_tag(abort_tag),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .rx_byte_tag_hi(rx_byte_tag_hi), .rx_byte_tag_lo(rx_byte_tag_lo),
    .rx_check_in(rx_check_in), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .mark_idle(mark_idle));
  ham_host_model host (.ref_clk(ref_clk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_addr(host_addr), .host_din(host_din),
    .host_dout(host_dout), .host_doe(host_doe));
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // words taken by the engine side
  always @(posedge ref_clk) begin
    if (tx_valid[0] && tx_ready[0]) txq.push_back({last_byte_tag[0], abort_tag[0], tx_data[0]});
  end
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic setp(input logic [7:0] pg);
    @(posedge ref_clk);
    page_sel <= pg;
  endtask : setp
  // engine side: byte held until taken, then the line shows its inverse
  task automatic rx_send(input logic [7:0] b, input logic last, input logic [1:0] t);
    int n;
    @(posedge ref_clk);
    rx_valid[0] <= 1'b1;
    rx_data[0] <= b;
    rx_last[0] <= last;
    {rx_byte_tag_hi[0], rx_byte_tag_lo[0]} <= t;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (rx_ready[0]) break;
    end
    rx_valid[0] <= 1'b0;
    rx_data[0] <= ~b;
  endtask : rx_send
  // expected filter verdict with recognition on
  function automatic logic passes(input logic [7:0] a1, a2, m2, b1, b2);
    logic m1, ms, all;
    m1 = !a1[AM_EN] || (b1[7:2] == a1[7:2] && (!m2[C2_SEVEN] || b1[1] == a1[1]));
    ms = !a2[AM_EN] || b2[7:1] == a2[7:1];
    all = a1[AM_EN] && b1[7:1] == ALL_CALL && (!a2[AM_EN] || b2[7:1] == ALL_CALL);
    return (m1 && ms) || all;
  endfunction : passes
  initial begin
    seed = 89;
    arst_n = 1'b0;
    page_sel = PAGE_CH0;
    tx_ready = 2'b00;
    rx_valid = 2'b00;
    rx_data = '0;
    rx_last = 2'b00;
    rx_byte_tag_hi = 2'b00;
    rx_byte_tag_lo = 2'b00;
    rx_check_in = {16'h0000, 16'($random(seed))};
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values and separate storage per page
    for (k = 0; k < 7; k++) begin
      v = 16'($random(seed));
      host.rd(rw_ofs[k], d, h);
      check(d, REG_RST, "reset value");
      host.wr(rw_ofs[k], v[7:0]);
      setp(PAGE_CH1);
      host.wr(rw_ofs[k], v[15:8]);
      host.rd(rw_ofs[k], d, h);
      check(d, v[15:8], "page one");
      setp(PAGE_CH0);
      host.rd(rw_ofs[k], d, h);
      check(d, v[7:0], "page zero");
    end
    host.rd(OFS_CHKH, d, h);
    check(d, rx_check_in[0][15:8], "check high");
    host.wr(OFS_EVFLAGS, 8'hff);
    host.rd(OFS_EVFLAGS, d, h);
    check(d, 8'h00, "read-only write");
    host.rd(5'h05, d, h);
    check(h, 1'b0, "unmapped drive");
    setp(8'h09);
    host.rd(OFS_ADDR1, d, h);
    check(h, 1'b0, "foreign page drive");
    setp(PAGE_CH0);
    $display("test registers done");
    // tagged words, tag self-clear, fill until refused, drain with stalls
    // controller one gets its own enable so the page split is visible on the pins
    setp(PAGE_CH1);
    host.wr(OFS_CTL1, 8'h40);
    setp(PAGE_CH0);
    host.wr(OFS_CTL1, 8'h70);
    for (j = 0; j < 9; j++) begin
      if (j == 3) host.wr(OFS_CTL1, 8'h6c);
      v = 16'($random(seed));
      host.wr(OFS_FIFO, v[7:0]);
      if (j < FIFO_D) exq.push_back({j == 0, j == 3, v[7:0]});
      if (j == 0 || j == 3) begin
        host.rd(OFS_CTL1, d, h);
        check(d, (j == 0) ? 8'h60 : 8'h64, "tag clear");
      end
    end
    check({rx_enable, tx_enable, mark_idle}, 10'b11_01_01, "control levels");
    check({tx_valid, rx_ready}, 10'b01_00, "stream levels");
    host.rd(OFS_STAT, d, h);
    check(d[3:0], 4'b1001, "tx full flags");
    for (j = 0; j < 80; j++) begin
      @(posedge ref_clk);
      tx_ready[0] <= 1'($random(seed)) | (j > 60);
    end
    @(posedge ref_clk);
    tx_ready[0] <= 1'b0;
    check(10'(txq.size()), 10'(FIFO_D), "tx word count");
    for (j = 0; j < FIFO_D && j < txq.size(); j++) check(txq[j], exq[j], "tx word");
    host.rd(OFS_STAT, d, h);
    check(d[3:0], 4'b0101, "tx empty flags");
    $display("test transmit done");
    // random filter settings with exact, all-call and one-bit-off addresses
    for (k = 0; k < 24; k++) begin
      r1 = 8'($random(seed));
      r2 = 8'($random(seed));
      c2 = 8'($random(seed)) & 8'h10;
      c1 = (8'($random(seed)) & 8'h80) | 8'h40;
      for (j = 0; j < 3; j++) begin
        p[j] = 8'($random(seed));
        tg[j] = 2'($random(seed));
      end
      if (k % 4 == 0) {p[0], p[1]} = {r1, r2};
      if (k % 4 == 1) {p[0], p[1]} = 16'hffff;
      if (k % 4 == 2) {p[0], p[1]} = {r1 ^ 8'h02, r2};
      host.wr(OFS_ADDR1, r1);
      host.wr(OFS_ADDR2, r2);
      host.wr(OFS_CTL2, c2);
      host.wr(OFS_CTL1, c1);
      for (j = 0; j < 3; j++) rx_send(p[j], j == 2, tg[j]);
      if (!c1[C1_ADREC] || passes(r1, r2, c2, p[0], p[1])) begin
        for (j = 0; j < 3; j++) begin
          host.rd(OFS_FIFO, d, h);
          check(d, p[j], "rx byte");
          host.rd(OFS_STAT, d, h);
          check(d[5:4], tg[j], "rx tags");
        end
      end else begin
        host.rd(OFS_FIFO, d, h);
        check(d, 8'h00, "dropped packet");
      end
      host.rd(OFS_STAT, d, h);
      check(d[0], 1'b1, "rx empty");
    end
    $display("test receive filter done");
    test_done();
  end
endmodule : testbench
